// [hdl/scr_device.sv]
// Device end: identity, byte-order and hardware configuration registers
// Notes on behaviour
// - Identity word: part code high, revision low
// - Byte-order register always reads 87654321h
// - Byte-order reads work during reset, not ready
// - Host may use byte-order read as spacer
// - Configuration register readable while not ready
// - Ready flag bit 27 sets after settling
// - Ready rising raises interrupt when enabled
// - Host avoids accesses while ready is clear; the host end still passes reads of byte-order, config, power and reset control
// - Ready mirrors power management bit zero
// - Crossover straps latched at reset, loader rewritable
// - Host writes zero to bit 21
// - Host writes one to bit 20
// - Transmit size field, 1KB steps, reset 5
// - Status FIFO 512 bytes, rest data
// - Host keeps transmit size at least 2KB
// - Receive side gets 16KB minus transmit
// - Host writes zeros to bits 13:12
// - Soft reset bit resets interface and registers
// - Soft reset restores defaults, kept bits stay
// - Soft reset clears errors, bit self-clears
// - Soft reset bit reads one during digital reset
// - Host reads once before trusting writes
`timescale 1ns/100ps
`include "scr_params.svh"
module scr_device
#(
  parameter logic [15:0] PART_ID       = `SCR_PART_ID,   // Arbitrary neutral value
  parameter logic [15:0] REVISION      = `SCR_REVISION,
  parameter int          SETTLE_CYCLES = `SCR_SETTLE_CYC,
  parameter int          SOFT_RESET_TRIGGER_CYCLES   = `SCR_SOFT_RESET_TRIGGER_CYC
)
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // Register link
  scr_link_if.dev          link,
  // Straps and loader
  input  wire logic [1:0]  autoCrossoverStrap,
  input  wire logic        eeLoadValid,
  input  wire logic [1:0]  eeLoadCrossover,
  // Reset control and interrupt enable
  input  wire logic        digitalReset,
  input  wire logic        readyIrqEnable,
  // Host MAC error events
  input  wire logic        txErrorEvent,
  input  wire logic        rxErrorEvent,
  // Status outputs
  output logic             deviceReady,
  output logic             readyIrq,
  output logic             softResetPulse,
  output logic             transmitterError,
  output logic             receiverError,
  output logic [1:0]       autoCrossoverEnable,
  output logic             mustWriteOneBit,
  output logic [3:0]       transmitFifoSize,
  output logic [14:0]      txDataBytes,
  output logic [14:0]      txStatusBytes,
  output logic [14:0]      rxBytes
);
  import scr_pkg::*;

  if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 65535 || SOFT_RESET_TRIGGER_CYCLES < 1 || SOFT_RESET_TRIGGER_CYCLES > 65535)
  begin : g_chk
    $error("scr_device: cycle counts must fit 1..65535");
  end

  typedef struct packed {
    scr_dev_state_t st;
    logic [15:0]    cnt;
    logic           ready;
    logic [1:0]     amdix;
    logic           rsvd21;
    logic           must_write_one_bit;
    logic [3:0]     txSize;
    logic [1:0]     rsvd13;
    logic           txErr;
    logic           rxErr;
    logic           ack;
    scr_word_t      rdata;
    logic           irq;
    logic           soft_reset_trigger;
  } scr_dev_regs_t;

  scr_dev_regs_t r_reg;
  scr_dev_regs_t r_next;
  scr_word_t     hwcfg;
  logic          take;
  logic          srstStart;
  logic          errClr;

  // Configuration word as read; unassigned positions stay zero, reserved bits 21 and 13:12 read back as written
  always_comb
  begin
    hwcfg                                 = '0;
    hwcfg[`SCR_READY_BIT]                 = r_reg.ready;
    hwcfg[`SCR_AMDIX2_BIT]                = r_reg.amdix[1];
    hwcfg[`SCR_AMDIX1_BIT]                = r_reg.amdix[0];
    hwcfg[`SCR_RSVD21_BIT]                = r_reg.rsvd21;
    hwcfg[`SCR_MBO_BIT]                   = r_reg.must_write_one_bit;
    hwcfg[`SCR_TXSZ_HI:`SCR_TXSZ_LO]      = r_reg.txSize;
    hwcfg[`SCR_RSVD13_HI:`SCR_RSVD13_LO]  = r_reg.rsvd13;
    hwcfg[`SCR_SOFT_RESET_TRIGGER_BIT]                  = (r_reg.st == SCR_SOFT_RESET_TRIGGER) | digitalReset;
  end

  // A request is taken once; the ack cycle masks the still-held request
  assign take      = link.req && !r_reg.ack;
  assign srstStart = take && link.wr && r_reg.ready && (link.addr == `SCR_HWCFG_OFS)
                     && link.wdata[`SCR_SOFT_RESET_TRIGGER_BIT];
  assign errClr    = srstStart || digitalReset;

  // Next-state logic for the whole device end
  always_comb
  begin
    r_next      = r_reg;
    r_next.ack  = 1'b0;
    r_next.irq  = 1'b0;
    r_next.soft_reset_trigger = 1'b0;

    // Error flags: a new event wins over the soft reset clear
    r_next.txErr = (r_reg.txErr & ~errClr) | txErrorEvent;
    r_next.rxErr = (r_reg.rxErr & ~errClr) | rxErrorEvent;

    // Loader may rewrite the strap copies at any time except while pin reset is held
    if (eeLoadValid)
    begin
      r_next.amdix = eeLoadCrossover;
    end

    // Settling and soft reset sequencing
    unique case (r_reg.st)
      SCR_SETTLE:
      begin
        r_next.cnt = r_reg.cnt + 16'h0001;
        if (r_reg.cnt == 16'(SETTLE_CYCLES - 1))
        begin
          r_next.st    = SCR_ACTIVE;
          r_next.ready = 1'b1;
          r_next.irq   = readyIrqEnable;
        end
      end
      SCR_ACTIVE:
      begin
        r_next.cnt = '0;
      end
      SCR_SOFT_RESET_TRIGGER:
      begin
        r_next.cnt = r_reg.cnt + 16'h0001;
        if (r_reg.cnt == 16'(SOFT_RESET_TRIGGER_CYCLES - 1))
        begin
          r_next.st  = SCR_SETTLE;
          r_next.cnt = '0;
        end
      end
    endcase

    // Bus access; reads are served in every state
    if (take)
    begin
      r_next.ack = 1'b1;
      unique case (link.addr)
        `SCR_ID_OFS:     r_next.rdata = {PART_ID, REVISION};
        `SCR_BYTE_OFS:   r_next.rdata = `SCR_BYTE_PATTERN;
        `SCR_HWCFG_OFS:  r_next.rdata = hwcfg;
        `SCR_PMCTL_OFS:  r_next.rdata = {31'h0000_0000, r_reg.ready};
        default:         r_next.rdata = '0;
      endcase
      if (link.wr)
      begin
        r_next.rdata = r_reg.rdata;
      end
      // Writes count only once ready; read-only and unassigned bits are dropped, reserved bits 21 and 13:12 are stored
      if (link.wr && r_reg.ready && link.addr == `SCR_HWCFG_OFS)
      begin
        r_next.rsvd21 = link.wdata[`SCR_RSVD21_BIT];
        r_next.must_write_one_bit    = link.wdata[`SCR_MBO_BIT];
        r_next.txSize = link.wdata[`SCR_TXSZ_HI:`SCR_TXSZ_LO];
        r_next.rsvd13 = link.wdata[`SCR_RSVD13_HI:`SCR_RSVD13_LO];
      end
    end

    // Soft reset: defaults back, straps are kept across it
    if (srstStart)
    begin
      r_next.st     = SCR_SOFT_RESET_TRIGGER;
      r_next.cnt    = '0;
      r_next.ready  = 1'b0;
      r_next.rsvd21 = 1'b0;
      r_next.must_write_one_bit    = 1'b0;
      r_next.txSize = `SCR_TXSZ_RESET;
      r_next.rsvd13 = 2'b00;
      r_next.soft_reset_trigger   = 1'b1;
    end

    // Digital reset holds state, ready and the writable fields at defaults until released; straps and error events are not held
    if (digitalReset)
    begin
      r_next.st     = SCR_SETTLE;
      r_next.cnt    = '0;
      r_next.ready  = 1'b0;
      r_next.rsvd21 = 1'b0;
      r_next.must_write_one_bit    = 1'b0;
      r_next.txSize = `SCR_TXSZ_RESET;
      r_next.rsvd13 = 2'b00;
      r_next.irq    = 1'b0;
    end

    // Pin reset; straps are sampled while it is held
    if (!rst_n)
    begin
      r_next        = '0;
      r_next.st     = SCR_SETTLE;
      r_next.txSize = `SCR_TXSZ_RESET;
      r_next.amdix  = autoCrossoverStrap;
    end
  end

  always_ff @(posedge core_clk)
  begin
    r_reg <= r_next;
  end

  // Memory split follows the programmed allocation
  scr_fifo_split u_split
  (
    .core_clk      (core_clk),
    .rst_n         (rst_n),
    .txSizeKb      (r_reg.txSize),
    .txDataBytes   (txDataBytes),
    .txStatusBytes (txStatusBytes),
    .rxBytes       (rxBytes)
  );

  // Outputs straight from state
  assign link.ack            = r_reg.ack;
  assign link.rdata          = r_reg.rdata;
  assign deviceReady         = r_reg.ready;
  assign readyIrq            = r_reg.irq;
  assign softResetPulse      = r_reg.soft_reset_trigger;
  assign transmitterError    = r_reg.txErr;
  assign receiverError       = r_reg.rxErr;
  assign autoCrossoverEnable = r_reg.amdix;
  assign mustWriteOneBit     = r_reg.must_write_one_bit;
  assign transmitFifoSize    = r_reg.txSize;
endmodule : scr_device

// [hdl/scr_fifo_split.sv]
// FIFO memory split derived from the programmed transmit allocation
`timescale 1ns/100ps
`include "scr_params.svh"
module scr_fifo_split
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // Allocation in kilobytes
  input  wire logic [3:0]  txSizeKb,
  // Byte counts
  output logic      [14:0] txDataBytes,
  output logic      [14:0] txStatusBytes,
  output logic      [14:0] rxBytes
);
  import scr_pkg::*;

  typedef struct packed {
    logic [14:0] txData;
    logic [14:0] rx;
  } scr_split_t;

  scr_split_t r_reg;
  scr_split_t r_next;
  logic [14:0] txBytes;

  // Status FIFO is carved out of the transmit share
  always_comb
  begin
    txBytes       = {1'b0, txSizeKb, 10'h000};
    r_next.txData = txBytes - `SCR_TXSTS_BYTES;
    r_next.rx     = `SCR_FIFO_TOTAL - txBytes;
    if (!rst_n)
    begin
      r_next = '0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    r_reg <= r_next;
  end

  assign txDataBytes   = r_reg.txData;
  assign txStatusBytes = `SCR_TXSTS_BYTES;
  assign rxBytes       = r_reg.rx;
endmodule : scr_fifo_split

// [hdl/scr_host.sv]
// Host end: AXI4-Lite command registers driving the device register link
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/100ps
`include "scr_params.svh"
module scr_host
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // Device link
  scr_link_if.host         link,
  // AXI4-Lite write
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  import scr_pkg::*;

  typedef struct packed {
    scr_host_state_t st;
    logic            req;
    logic            wr;
    scr_addr_t       addr;
    scr_word_t       wdata;
    logic            awHeld;
    logic [3:0]      awAddr;
    logic            wHeld;
    logic            wFull;
    scr_word_t       wData;
    logic            bvalid;
    logic [1:0]      bresp;
    logic            rvalid;
    scr_word_t       rdata;
    logic [1:0]      rresp;
    scr_word_t       cmdData;
    scr_word_t       lastRead;
    logic            done;
    logic            refused;
    logic            devReady;
    logic            initDone;
  } scr_host_regs_t;

  scr_host_regs_t r_reg;
  scr_host_regs_t r_next;
  scr_word_t      stat;
  scr_word_t      fixed;
  scr_addr_t      cAddr;
  logic           cWr;
  logic           allowed;

  // Status word and the command fields of the pending write
  always_comb
  begin
    stat    = {27'h000_0000, r_reg.initDone, r_reg.devReady, r_reg.refused, r_reg.done,
               r_reg.st == SCR_H_XFER};
    cAddr   = r_reg.wData[9:0];
    cWr     = r_reg.wData[`SCR_H_WR_BIT];
    allowed = r_reg.devReady || (!cWr && (cAddr == `SCR_HWCFG_OFS || cAddr == `SCR_PMCTL_OFS
              || cAddr == `SCR_BYTE_OFS || cAddr == `SCR_RSTCTL_OFS));
    // Configuration writes get the mandatory bit values and a legal size
    fixed = r_reg.cmdData;
    if (cAddr == `SCR_HWCFG_OFS)
    begin
      fixed[`SCR_RSVD21_BIT]                = 1'b0;
      fixed[`SCR_MBO_BIT]                   = 1'b1;
      fixed[`SCR_RSVD13_HI:`SCR_RSVD13_LO]  = 2'b00;
      if (fixed[`SCR_TXSZ_HI:`SCR_TXSZ_LO] < `SCR_TXSZ_MIN)
      begin
        fixed[`SCR_TXSZ_HI:`SCR_TXSZ_LO] = `SCR_TXSZ_MIN;
      end
      if (fixed[`SCR_TXSZ_HI:`SCR_TXSZ_LO] > `SCR_TXSZ_MAX)
      begin
        fixed[`SCR_TXSZ_HI:`SCR_TXSZ_LO] = `SCR_TXSZ_MAX;
      end
    end
  end

  // Next-state logic for bus slave and link master
  always_comb
  begin
    r_next = r_reg;
    if (s_axi_awvalid && s_axi_awready)
    begin
      r_next.awHeld = 1'b1;
      r_next.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      r_next.wHeld = 1'b1;
      r_next.wData = s_axi_wdata;
      // Strobes are only valid with their own beat, so keep them with the data
      r_next.wFull = (s_axi_wstrb == 4'hF);
    end
    if (r_reg.bvalid && s_axi_bready)
    begin
      r_next.bvalid = 1'b0;
    end
    if (r_reg.rvalid && s_axi_rready)
    begin
      r_next.rvalid = 1'b0;
    end

    // Read channel answers one cycle after the address
    if (s_axi_arvalid && s_axi_arready)
    begin
      r_next.rvalid = 1'b1;
      r_next.rresp  = 2'b00;
      unique case (s_axi_araddr)
        `SCR_H_CMD_OFS:   r_next.rdata = '0;
        `SCR_H_WDATA_OFS: r_next.rdata = r_reg.cmdData;
        `SCR_H_RDATA_OFS: r_next.rdata = r_reg.lastRead;
        `SCR_H_STAT_OFS:  r_next.rdata = stat;
        default:
        begin
          r_next.rdata = '0;
          r_next.rresp = 2'b10;
        end
      endcase
    end

    // Write executes once address and data are both held
    if (r_reg.awHeld && r_reg.wHeld)
    begin
      r_next.awHeld = 1'b0;
      r_next.wHeld  = 1'b0;
      r_next.bvalid = 1'b1;
      r_next.bresp  = 2'b00;
      if (r_reg.awAddr == `SCR_H_WDATA_OFS && r_reg.wFull)
      begin
        r_next.cmdData = r_reg.wData;
      end
      else if (r_reg.awAddr == `SCR_H_CMD_OFS)
      begin
        // A go while busy or before the first read is dropped and flagged
        if (r_reg.wData[`SCR_H_GO_BIT])
        begin
          r_next.done    = 1'b0;
          r_next.refused = 1'b1;
          if (r_reg.st == SCR_H_IDLE && r_reg.initDone && allowed)
          begin
            r_next.refused = 1'b0;
            r_next.st      = SCR_H_XFER;
            r_next.req     = 1'b1;
            r_next.wr      = cWr;
            r_next.addr    = cAddr;
            r_next.wdata   = fixed;
          end
        end
      end
      else if (r_reg.awAddr != `SCR_H_WDATA_OFS)
      begin
        r_next.bresp = 2'b10;
      end
    end

    // Link sequencing; the first access after reset is a read
    unique case (r_reg.st)
      SCR_H_INIT:
      begin
        r_next.st   = SCR_H_XFER;
        r_next.req  = 1'b1;
        r_next.wr   = 1'b0;
        r_next.addr = `SCR_BYTE_OFS;
      end
      SCR_H_IDLE:
      begin
      end
      SCR_H_XFER:
      begin
        if (link.ack)
        begin
          r_next.req      = 1'b0;
          r_next.st       = SCR_H_IDLE;
          r_next.done     = 1'b1;
          r_next.initDone = 1'b1;
          if (!r_reg.wr)
          begin
            r_next.lastRead = link.rdata;
          end
          if (!r_reg.wr && r_reg.addr == `SCR_HWCFG_OFS)
          begin
            r_next.devReady = link.rdata[`SCR_READY_BIT];
          end
          if (r_reg.wr && r_reg.addr == `SCR_HWCFG_OFS && r_reg.wdata[`SCR_SOFT_RESET_TRIGGER_BIT])
          begin
            r_next.devReady = 1'b0;
          end
        end
      end
    endcase

    if (!rst_n)
    begin
      r_next    = '0;
      r_next.st = SCR_H_INIT;
    end
  end

  always_ff @(posedge core_clk)
  begin
    r_reg <= r_next;
  end

  // Handshake outputs from held-state flags
  assign s_axi_awready = !r_reg.awHeld && !r_reg.bvalid && rst_n;
  assign s_axi_wready  = !r_reg.wHeld && !r_reg.bvalid && rst_n;
  assign s_axi_arready = !r_reg.rvalid && rst_n;
  assign s_axi_bvalid  = r_reg.bvalid;
  assign s_axi_bresp   = r_reg.bresp;
  assign s_axi_rvalid  = r_reg.rvalid;
  assign s_axi_rdata   = r_reg.rdata;
  assign s_axi_rresp   = r_reg.rresp;
  assign link.req      = r_reg.req;
  assign link.wr       = r_reg.wr;
  assign link.addr     = r_reg.addr;
  assign link.wdata    = r_reg.wdata;
endmodule : scr_host

// [inc/scr_link_if.sv]
// Register link between the host processor end and the device end
`timescale 1ns/100ps
interface scr_link_if;
  import scr_pkg::*;

  // Request, held by the host until ack
  logic      req;
  logic      wr;
  scr_addr_t addr;
  scr_word_t wdata;
  // Answer, one-cycle ack with read data
  logic      ack;
  scr_word_t rdata;

  modport dev (input req, input wr, input addr, input wdata, output ack, output rdata);
  modport host (output req, output wr, output addr, output wdata, input ack, input rdata);
endinterface : scr_link_if

// [inc/scr_params.svh]
// Offsets, field positions, reset values and timing counts of the system config registers
`ifndef SCR_PARAMS_SVH
`define SCR_PARAMS_SVH

// Register byte offsets on the device link
`define SCR_ID_OFS        10'h050
`define SCR_BYTE_OFS      10'h064
`define SCR_HWCFG_OFS     10'h074
`define SCR_PMCTL_OFS     10'h084
`define SCR_RSTCTL_OFS    10'h1F8

// Fixed values
`define SCR_BYTE_PATTERN  32'h8765_4321
`define SCR_PART_ID       16'hA5C3
`define SCR_REVISION      16'h0001

// Hardware configuration field positions
`define SCR_READY_BIT     27
`define SCR_AMDIX2_BIT    26
`define SCR_AMDIX1_BIT    25
`define SCR_RSVD21_BIT    21
`define SCR_MBO_BIT       20
`define SCR_TXSZ_HI       19
`define SCR_TXSZ_LO       16
`define SCR_RSVD13_HI     13
`define SCR_RSVD13_LO     12
`define SCR_SOFT_RESET_TRIGGER_BIT      0

// Reset values and FIFO sizing
`define SCR_TXSZ_RESET    4'h5
`define SCR_TXSZ_MIN      4'h2
`define SCR_TXSZ_MAX      4'hE
`define SCR_TXSTS_BYTES   15'h0200
`define SCR_FIFO_TOTAL    15'h4000

// Timing: times in ns, counts derived at 10 MHz
`define SCR_CLK_NS        100
`define SCR_SETTLE_NS     1000
`define SCR_SOFT_RESET_TRIGGER_NS       500
`define SCR_SETTLE_CYC    ((`SCR_SETTLE_NS + `SCR_CLK_NS - 1) / `SCR_CLK_NS)
`define SCR_SOFT_RESET_TRIGGER_CYC      ((`SCR_SOFT_RESET_TRIGGER_NS + `SCR_CLK_NS - 1) / `SCR_CLK_NS)

// Host end register offsets on AXI4-Lite
`define SCR_H_CMD_OFS     4'h0
`define SCR_H_WDATA_OFS   4'h4
`define SCR_H_RDATA_OFS   4'h8
`define SCR_H_STAT_OFS    4'hC
`define SCR_H_GO_BIT      31
`define SCR_H_WR_BIT      16

`endif

// [inc/scr_pkg.sv]
// Types shared by both ends of the system config register link
package scr_pkg;

  typedef enum logic [2:0] {
    SCR_SETTLE = 3'b001,
    SCR_ACTIVE = 3'b010,
    SCR_SOFT_RESET_TRIGGER   = 3'b100
  } scr_dev_state_t;

  typedef enum logic [2:0] {
    SCR_H_INIT = 3'b001,
    SCR_H_IDLE = 3'b010,
    SCR_H_XFER = 3'b100
  } scr_host_state_t;

  typedef logic [9:0]  scr_addr_t;
  typedef logic [31:0] scr_word_t;

endpackage : scr_pkg

// [testbench/scr_link_properties.sv]
// Assertions on the register link between host and device ends
`timescale 1ns/100ps
`include "scr_params.svh"
module scr_link_properties
(
  // Clock and reset
  input wire logic             core_clk,
  input wire logic             rst_n,
  // Link signals
  input wire logic             req,
  input wire logic             wr,
  input wire scr_pkg::scr_addr_t addr,
  input wire scr_pkg::scr_word_t wdata,
  input wire logic             ack,
  input wire scr_pkg::scr_word_t rdata
);
  import scr_pkg::*;
  logic seenRead;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // Remembers a read since reset; writes before it may be lost
  always_ff @(posedge core_clk)
    seenRead <= rst_n && (seenRead || (req && !ack && !wr));

  // Request taken on a free edge
  sequence taken;
    req && !ack;
  endsequence
  sequence byteRead;
    taken ##0 (!wr && addr == `SCR_BYTE_OFS);
  endsequence
  sequence hwWrite;
    req && wr && addr == `SCR_HWCFG_OFS;
  endsequence

  a_ack_one_later: assert property (taken |=> ack)
    else $error("ack not one cycle after request");
  a_ack_one_cycle: assert property (ack |=> !ack)
    else $error("ack longer than one cycle");
  a_ack_has_req: assert property (ack |-> $past(req))
    else $error("ack without request");
  a_req_drops: assert property (ack |=> !req)
    else $error("request kept after ack");
  a_req_holds: assert property (taken |=> $stable({wr, addr, wdata}))
    else $error("request changed before ack");
  a_rdata_holds: assert property (!(req && !ack && !wr) |=> $stable(rdata))
    else $error("read data moved without a read");
  a_byte_pattern: assert property (byteRead |=> rdata == `SCR_BYTE_PATTERN)
    else $error("byte order word wrong");
  a_id_word: assert property (taken ##0 (!wr && addr == `SCR_ID_OFS) |=>
    rdata == {`SCR_PART_ID, `SCR_REVISION})
    else $error("identity word wrong");
  a_read_first: assert property (req && wr |-> seenRead)
    else $error("write before first read");
  a_must_fields: assert property (hwWrite |-> !wdata[21] && wdata[20] && wdata[13:12] == 2'b00)
    else $error("fixed config bits written wrong");
  a_size_floor: assert property (hwWrite |-> wdata[19:16] inside {[4'h2:4'hE]})
    else $error("transmit size out of range");
endmodule : scr_link_properties

// [testbench/tb.sv]
// Bench joining host and device ends, driven over AXI4-Lite
`timescale 1ns/100ps
`include "scr_params.svh"
module tb;
  import scr_pkg::*;
  // Clock, reset, device side
  logic        core_clk = 0, rst_n = 0, digitalReset = 0, readyIrqEnable = 1, eeLoadValid = 0;
  logic        txErrorEvent = 0, rxErrorEvent = 0, deviceReady, readyIrq, softResetPulse;
  logic        transmitterError, receiverError, mustWriteOneBit;
  logic [1:0]  autoCrossoverStrap = 2'b10, eeLoadCrossover = 2'b01, autoCrossoverEnable;
  logic [3:0]  transmitFifoSize;
  logic [14:0] txDataBytes, txStatusBytes, rxBytes;
  // AXI4-Lite
  logic [3:0]  s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  int          failCount = 0, numChecks = 0, cyc = 0, irqCount = 0, srstCount = 0;

  scr_link_if link ();
  scr_host i_scr_host (.core_clk, .rst_n, .link(link.host), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  scr_device i_scr_device (.core_clk, .rst_n, .link(link.dev), .autoCrossoverStrap, .eeLoadValid,
    .eeLoadCrossover, .digitalReset, .readyIrqEnable, .txErrorEvent, .rxErrorEvent, .deviceReady, .readyIrq,
    .softResetPulse, .transmitterError, .receiverError, .autoCrossoverEnable, .mustWriteOneBit,
    .transmitFifoSize, .txDataBytes, .txStatusBytes, .rxBytes);
  scr_link_properties i_scr_link_properties (.core_clk, .rst_n, .req(link.req), .wr(link.wr),
    .addr(link.addr), .wdata(link.wdata), .ack(link.ack), .rdata(link.rdata));

  // Clock at 10 MHz
  always #50 core_clk = ~core_clk;

  // Pulse counters and hang guard
  always @(posedge core_clk)
  begin
    irqCount += (readyIrq === 1'b1);
    srstCount += (softResetPulse === 1'b1);
    cyc++;
    if (cyc == 20000)
    begin
      failCount++;
      test_done();
    end
  end

  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    numChecks++;
    if (got !== exp)
    begin
      failCount++;
      $display("ERROR %s expected %h seen %h", n, exp, got);
    end
  endtask : chk

  task automatic test_done();
    $display("checks %0d mismatches %0d", numChecks, failCount);
    if (failCount == 0 && numChecks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : test_done

  // Ready is sampled at the falling edge, where a registered value has settled
  task automatic axw(input logic [3:0] a, input logic [31:0] d);
    logic aw, w, b;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(negedge core_clk);
      aw = s_axi_awready & s_axi_awvalid;
      w = s_axi_wready & s_axi_wvalid;
      b = s_axi_bvalid;
      @(posedge core_clk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      if (b) s_axi_bready <= 1'b0;
    end
    while (b !== 1'b1);
  endtask : axw

  task automatic axr(input logic [3:0] a, output logic [31:0] d);
    logic ar, r;
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(negedge core_clk);
      ar = s_axi_arready & s_axi_arvalid;
      r = s_axi_rvalid;
      d = s_axi_rdata;
      @(posedge core_clk);
      if (ar) s_axi_arvalid <= 1'b0;
      if (r) s_axi_rready <= 1'b0;
    end
    while (r !== 1'b1);
  endtask : axr

  // One device access through the host command registers
  task automatic cmd(input logic wr, input scr_addr_t a, input scr_word_t d, output scr_word_t q);
    axw(`SCR_H_WDATA_OFS, d);
    axw(`SCR_H_CMD_OFS, {1'b1, 14'h0, wr, 6'h0, a});
    do
      axr(`SCR_H_STAT_OFS, q);
    while (q[0] !== 1'b0);
    axr(`SCR_H_RDATA_OFS, q);
  endtask : cmd

  // Waits for ready, then expects the default configuration word
  task automatic wait_ready();
    scr_word_t q;
    int n;
    n = 0;
    do
    begin
      @(negedge core_clk);
      n++;
    end
    while (deviceReady !== 1'b1 && n < 40);
    chk("settle", n < 20, 1);
    cmd(1'b0, `SCR_HWCFG_OFS, 32'h0, q);
    chk("hwcfgDef", q, {4'h0, 1'b1, autoCrossoverStrap, 5'h0, 4'h5, 16'h0});
    chk("sizeOut", transmitFifoSize, 4'h5);
  endtask : wait_ready

  task automatic t_reads();
    scr_word_t q;
    cmd(1'b0, `SCR_ID_OFS, 32'h0, q);
    chk("idWord", q, {`SCR_PART_ID, `SCR_REVISION});
    cmd(1'b0, `SCR_BYTE_OFS, 32'h0, q);
    chk("byteWord", q, `SCR_BYTE_PATTERN);
    cmd(1'b0, `SCR_PMCTL_OFS, 32'h0, q);
    chk("pmReady", q[0], 1'b1);
    cmd(1'b0, 10'h100, 32'h0, q);
    chk("unmapped", q, 32'h0);
  endtask : t_reads

  task automatic t_size();
    scr_word_t q;
    for (int s = 2; s <= 14; s += 6)
    begin
      cmd(1'b1, `SCR_HWCFG_OFS, {12'hFFF, s[3:0], 16'hFFFE}, q);
      cmd(1'b0, `SCR_HWCFG_OFS, 32'h0, q);
      chk("hwcfgSet", q, {4'h0, 1'b1, autoCrossoverStrap, 5'h01, s[3:0], 16'h0});
      chk("txData", txDataBytes, s * 1024 - 512);
      chk("txStat", txStatusBytes, 512);
      chk("rxSize", rxBytes, 16384 - s * 1024);
    end
    // Size zero is lifted to the floor, must-be-one bit forced
    cmd(1'b1, `SCR_HWCFG_OFS, 32'h0, q);
    chk("sizeFloor", {mustWriteOneBit, transmitFifoSize}, 5'h12);
  endtask : t_size

  task automatic t_soft();
    scr_word_t q;
    @(posedge core_clk);
    txErrorEvent <= 1'b1;
    rxErrorEvent <= 1'b1;
    @(posedge core_clk);
    txErrorEvent <= 1'b0;
    rxErrorEvent <= 1'b0;
    @(negedge core_clk);
    chk("errSet", {transmitterError, receiverError}, 2'b11);
    cmd(1'b1, `SCR_HWCFG_OFS, 32'h0009_0001, q);
    wait_ready();
    chk("errClr", {transmitterError, receiverError}, 2'b00);
    chk("srstPulses", srstCount, 1);
  endtask : t_soft

  task automatic t_digital();
    scr_word_t q;
    @(posedge core_clk);
    digitalReset <= 1'b1;
    readyIrqEnable <= 1'b0; // Ready after this reset must not interrupt
    cmd(1'b0, `SCR_HWCFG_OFS, 32'h0, q);
    chk("srstDig", q[0], 1'b1);
    chk("notReady", {q[27], deviceReady}, 2'b00);
    cmd(1'b0, `SCR_BYTE_OFS, 32'h0, q);
    chk("byteNotReady", q, `SCR_BYTE_PATTERN);
    // A write while not ready is refused by the host end
    cmd(1'b1, `SCR_HWCFG_OFS, 32'h0, q);
    axr(`SCR_H_STAT_OFS, q);
    chk("refused", q[2], 1'b1);
    @(posedge core_clk);
    digitalReset <= 1'b0;
    wait_ready();
  endtask : t_digital

  // Loader rewrites the strap copies
  task automatic t_loader();
    scr_word_t q;
    @(posedge core_clk);
    eeLoadValid <= 1'b1;
    @(posedge core_clk);
    eeLoadValid <= 1'b0;
    cmd(1'b0, `SCR_HWCFG_OFS, 32'h0, q);
    chk("loaderCopy", {q[26:25], autoCrossoverEnable}, {2{eeLoadCrossover}});
  endtask : t_loader

  // Main sequence
  initial
  begin
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    @(negedge core_clk);
    chk("sizeRst", transmitFifoSize, 4'h5);
    chk("strapRst", autoCrossoverEnable, autoCrossoverStrap);
    wait_ready();
    t_reads();
    t_size();
    t_soft();
    t_digital();
    t_loader();
    chk("irqPulses", irqCount, 2);
    test_done();
  end
endmodule : tb
